// *** hdl/lfd_regs.vh ***
// Purpose: Constants for the LED fault diagnostic serial slave
// Assumes: 25 MHz reference clock
// Notes: Register offsets are byte register indices on the serial bus
`ifndef LFD_REGS_VH
`define LFD_REGS_VH
`define LFD_ADDR_GND 7'h11
`define LFD_ADDR_SCL 7'h15
`define LFD_ADDR_SDA 7'h51
`define LFD_ADDR_VIN 7'h55
`define LFD_REG_CH_EN 8'h03
`define LFD_REG_TEST 8'h19
`define LFD_REG_SHORT 8'h1C
`define LFD_REG_FAULT 8'h1D
`define LFD_TEST_DIAG_BIT 5
`define LFD_CH_EN_RST 8'h3F
`define LFD_TEST_RST 8'h00
`define LFD_CLK_HZ 25000000
`define LFD_SETTLE_NS 20000
`define LFD_SETTLE_CYC ((`LFD_SETTLE_NS * (`LFD_CLK_HZ / 1000000) + 999) / 1000)
`endif

// *** hdl/lfd_diag.v ***
// Purpose: LED pin diagnostic sequencer and short-to-ground channel gating
// Assumes: Pin comparator levels already synchronised
// Notes: One run samples all six pins after a settle time
`timescale 1ns/1ps
`include "lfd_regs.vh"
module lfd_diag (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire start_in,
    input wire [5:0] pin_low_in,
    input wire [5:0] pin_fault_in,
    input wire [5:0] ch_en_in,
    output reg busy_out,
    output reg [5:0] short_out,
    output reg [5:0] fault_out,
    output reg [5:0] drive_en_out
);
    localparam integer SETTLE_CYC = `LFD_SETTLE_CYC;
    localparam [14:0] SETTLE = SETTLE_CYC[14:0];
    reg [14:0] cnt_q;
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            busy_out <= 1'b1;
            cnt_q <= 15'h0000;
            short_out <= 6'h00;
            fault_out <= 6'h00;
            drive_en_out <= 6'h00;
        end else begin
            if (busy_out) begin
                if (cnt_q == SETTLE - 15'h0001) begin
                    // Capture results, short bits only valid with fault set
                    short_out <= pin_low_in;
                    fault_out <= pin_fault_in | pin_low_in;
                    busy_out <= 1'b0;
                    cnt_q <= 15'h0000;
                end else begin
                    cnt_q <= cnt_q + 15'h0001;
                end
            end else if (start_in) begin
                busy_out <= 1'b1;
            end
            // Shorted channels off, restored once short is gone
            drive_en_out <= ch_en_in & ~(short_out & pin_low_in);
        end
    end
endmodule // lfd_diag

// *** hdl/lfd_top.v ***
// Purpose: Serial slave with LED fault diagnostic result registers
// Assumes: Bus at most 400 kbit/s; pins sampled by 25 MHz clock
// Notes:
`timescale 1ns/1ps
`include "lfd_regs.vh"
module lfd_top (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire scl_in,
    input wire serial_data_pin_in,
    output reg serial_data_pin_oe_out,
    output reg serial_data_pin_out,
    input wire strap_gnd_in,
    input wire strap_scl_in,
    input wire strap_sda_in,
    input wire [5:0] pin_low_in,
    input wire [5:0] pin_fault_in,
    output reg [5:0] drive_en_out,
    output reg diag_busy_out
);
    localparam [7:0] ST_IDLE = 8'h01;
    localparam [7:0] ST_ADDR = 8'h02;
    localparam [7:0] ST_AACK = 8'h04;
    localparam [7:0] ST_REG = 8'h08;
    localparam [7:0] ST_RACK = 8'h10;
    localparam [7:0] ST_WDAT = 8'h20;
    localparam [7:0] ST_RDAT = 8'h40;
    localparam [7:0] ST_MACK = 8'h80;
    // ====================================================
    // Input synchronisers
    reg [1:0] scl_s_q, sda_s_q, sg_q, sc_q, sd_q;
    reg [5:0] low_a_q, low_b_q, flt_a_q, flt_b_q;
    reg scl_d_q, sda_d_q;
    always @(posedge ref_clk_in) begin
        scl_s_q <= {scl_s_q[0], scl_in};
        sda_s_q <= {sda_s_q[0], serial_data_pin_in};
        sg_q <= {sg_q[0], strap_gnd_in};
        sc_q <= {sc_q[0], strap_scl_in};
        sd_q <= {sd_q[0], strap_sda_in};
        low_a_q <= pin_low_in;
        low_b_q <= low_a_q;
        flt_a_q <= pin_fault_in;
        flt_b_q <= flt_a_q;
        scl_d_q <= scl_s_q[1];
        sda_d_q <= sda_s_q[1];
    end
    wire scl = scl_s_q[1];
    wire sda = sda_s_q[1];
    wire scl_rise = scl & ~scl_d_q;
    wire scl_fall = ~scl & scl_d_q;
    wire start_c = scl & scl_d_q & sda_d_q & ~sda;
    wire stop_c = scl & scl_d_q & ~sda_d_q & sda;
    // ====================================================
    // Strap address, caught after reset release
    reg [6:0] addr_q;
    reg strap_done_q;
    function [6:0] strap_addr;
        input g, c, d;
        begin
            if (g) strap_addr = `LFD_ADDR_GND;
            else if (c) strap_addr = `LFD_ADDR_SCL;
            else if (d) strap_addr = `LFD_ADDR_SDA;
            else strap_addr = `LFD_ADDR_VIN;
        end
    endfunction
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            addr_q <= `LFD_ADDR_VIN;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            addr_q <= strap_addr(sg_q[1], sc_q[1], sd_q[1]);
            strap_done_q <= 1'b1;
        end
    end
    // ====================================================
    // Registers and diagnostic
    reg [7:0] ch_en_q, test_q, ptr_q;
    wire busy;
    wire [5:0] short_w, fault_w, drv_w;
    reg busy_d_q;
    wire diag_start = test_q[`LFD_TEST_DIAG_BIT] & ~busy & ~busy_d_q;
    lfd_diag u_diag (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .start_in(diag_start),
        .pin_low_in(low_b_q),
        .pin_fault_in(flt_b_q),
        .ch_en_in(ch_en_q[5:0]),
        .busy_out(busy),
        .short_out(short_w),
        .fault_out(fault_w),
        .drive_en_out(drv_w)
    );
    function [7:0] rd_mux;
        input [7:0] a;
        input [7:0] en, tst;
        input [5:0] sh, fl;
        begin
            case (a)
                `LFD_REG_CH_EN: rd_mux = en;
                `LFD_REG_TEST: rd_mux = tst;
                `LFD_REG_SHORT: rd_mux = {2'b00, sh};
                `LFD_REG_FAULT: rd_mux = {2'b00, fl};
                default: rd_mux = 8'h00;
            endcase
        end
    endfunction
    // ====================================================
    // Serial slave engine
    reg [7:0] st_q, sh_q;
    reg [3:0] bit_q;
    reg rw_q, nack_q;
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            st_q <= ST_IDLE;
            sh_q <= 8'h00;
            bit_q <= 4'h0;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
            ptr_q <= 8'h00;
            ch_en_q <= `LFD_CH_EN_RST;
            test_q <= `LFD_TEST_RST;
            busy_d_q <= 1'b1;
            serial_data_pin_oe_out <= 1'b0;
            serial_data_pin_out <= 1'b0;
            drive_en_out <= 6'h00;
            diag_busy_out <= 1'b1;
        end else begin
            busy_d_q <= busy;
            drive_en_out <= drv_w;
            diag_busy_out <= busy;
            if (busy_d_q & ~busy)
                test_q[`LFD_TEST_DIAG_BIT] <= 1'b0;
            if (start_c) begin
                st_q <= ST_ADDR;
                bit_q <= 4'h0;
                serial_data_pin_oe_out <= 1'b0;
            end else if (stop_c) begin
                st_q <= ST_IDLE;
                serial_data_pin_oe_out <= 1'b0;
            end else begin
                case (st_q)
                    ST_IDLE: begin
                        serial_data_pin_oe_out <= 1'b0;
                    end
                    ST_ADDR, ST_REG, ST_WDAT: begin
                        if (scl_rise) begin
                            sh_q <= {sh_q[6:0], sda};
                            bit_q <= bit_q + 4'h1;
                        end else if (scl_fall && bit_q == 4'h8) begin
                            bit_q <= 4'h0;
                            if (st_q == ST_ADDR) begin
                                if (sh_q[7:1] == addr_q) begin
                                    rw_q <= sh_q[0];
                                    serial_data_pin_oe_out <= 1'b1;
                                    st_q <= ST_AACK;
                                end else begin
                                    st_q <= ST_IDLE;
                                end
                            end else begin
                                serial_data_pin_oe_out <= 1'b1;
                                if (st_q == ST_REG) begin
                                    ptr_q <= sh_q;
                                end else begin
                                    if (ptr_q == `LFD_REG_CH_EN)
                                        ch_en_q <= {2'b00, sh_q[5:0]};
                                    if (ptr_q == `LFD_REG_TEST)
                                        test_q <= sh_q | (test_q & ((busy_d_q & ~busy) ? 8'h00 : 8'h20));
                                    ptr_q <= ptr_q + 8'h01;
                                end
                                st_q <= ST_RACK;
                            end
                        end
                    end
                    ST_AACK, ST_RACK: begin
                        if (scl_fall) begin
                            if (st_q == ST_AACK && rw_q) begin
                                sh_q <= rd_mux(ptr_q, ch_en_q, test_q, short_w, fault_w);
                                serial_data_pin_oe_out <= 1'b1;
                                st_q <= ST_RDAT;
                            end else begin
                                serial_data_pin_oe_out <= 1'b0;
                                st_q <= (st_q == ST_AACK) ? ST_REG : ST_WDAT;
                            end
                        end
                    end
                    ST_RDAT: begin
                        serial_data_pin_oe_out <= ~sh_q[7];
                        if (scl_fall) begin
                            bit_q <= bit_q + 4'h1;
                            if (bit_q == 4'h7) begin
                                serial_data_pin_oe_out <= 1'b0;
                                ptr_q <= ptr_q + 8'h01;
                                bit_q <= 4'h0;
                                st_q <= ST_MACK;
                            end else begin
                                sh_q <= {sh_q[6:0], 1'b0};
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise)
                            nack_q <= sda;
                        if (scl_fall) begin
                            if (nack_q) begin
                                st_q <= ST_IDLE;
                            end else begin
                                sh_q <= rd_mux(ptr_q, ch_en_q, test_q, short_w, fault_w);
                                st_q <= ST_RDAT;
                            end
                        end
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end
endmodule // lfd_top

// *** verif/lfd_monitor.sv ***
// Purpose: Port checks for lfd_top
// Assumes: 25 MHz clock, sync reset
// Notes: Bound to every lfd_top
`timescale 1ns/1ps
module lfd_monitor (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire scl_in,
    input wire serial_data_pin_oe_out,
    input wire serial_data_pin_out,
    input wire [5:0] pin_low_in,
    input wire [5:0] pin_fault_in,
    input wire [5:0] drive_en_out,
    input wire diag_busy_out
);
    // ====================
    // Checks
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    reg [9:0] busy_q;
    always @(posedge ref_clk_in)
        busy_q <= (!rst_n_in || !diag_busy_out) ? 10'h000 : busy_q + 10'h001;
    sda_low_a: assert property (serial_data_pin_out == 1'b0)
        else $error("data out high");
    oe_scl_low_a: assert property ($changed(serial_data_pin_oe_out) |-> !scl_in)
        else $error("data moved while clock high");
    ack_hold_a: assert property ($rose(serial_data_pin_oe_out) |-> serial_data_pin_oe_out[*8])
        else $error("pull too short");
    rst_busy_a: assert property ($rose(rst_n_in) |-> diag_busy_out[*8])
        else $error("no run after reset");
    rerun_busy_a: assert property ($rose(diag_busy_out) |-> diag_busy_out[*8])
        else $error("run too short");
    busy_max_a: assert property (busy_q < 10'h2BC)
        else $error("run never ends");
    gnd_off_a: assert property ($fell(diag_busy_out) && pin_low_in == $past(pin_low_in, 8)
        |-> ##4 (drive_en_out & pin_low_in) == 6'h00) else $error("shorted channel driven");
    open_keep_a: assert property (!diag_busy_out && pin_low_in == 6'h00 &&
        $changed(pin_fault_in) |=> $stable(drive_en_out)[*4]) else $error("drive moved on fault");
    cover property ($fell(diag_busy_out));
    cover property ($rose(serial_data_pin_oe_out));
    cover property (drive_en_out == 6'h32);
endmodule // lfd_monitor
bind lfd_top lfd_monitor u_lfd_monitor (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .scl_in(scl_in), .serial_data_pin_oe_out(serial_data_pin_oe_out),
    .serial_data_pin_out(serial_data_pin_out), .pin_low_in(pin_low_in),
    .pin_fault_in(pin_fault_in), .drive_en_out(drive_en_out), .diag_busy_out(diag_busy_out));

// *** verif/lfd_master.sv ***
// Purpose: Serial bus master model
// Assumes: Pull-up on data line
// Notes: Bit period 2560 ns
`timescale 1ns/1ps
module lfd_master (
    output reg scl_out,
    output reg sda_oe_out,
    input wire sda_in
);
    // ====================
    // Bus phases
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    task tx(input b, output r);
        #200 sda_oe_out = ~b;
        #1080 scl_out = 1'b1;
        #640 r = sda_in;
        #640 scl_out = 1'b0;
    endtask
    task rs;
        #200 sda_oe_out = 1'b0;
        #1080 scl_out = 1'b1;
        #640 sda_oe_out = 1'b1;
        #640 scl_out = 1'b0;
    endtask
    task sp;
        #200 sda_oe_out = 1'b1;
        #1080 scl_out = 1'b1;
        #640 sda_oe_out = 1'b0;
        #640;
    endtask
    task xb(input [7:0] d, output [7:0] q, output ack);
        reg r;
        for (int i = 7; i >= 0; i--) tx(d[i], q[i]);
        tx(1'b1, r);
        ack = ~r;
    endtask
    task xa(output [7:0] q);
        reg r;
        for (int i = 7; i >= 0; i--) tx(1'b1, q[i]);
        tx(1'b0, r);
    endtask
endmodule // lfd_master

// *** verif/tb_top.sv ***
// Purpose: Bench for lfd_top
// Assumes: Master model on the bus
// Notes: Straps, diagnostic and results
`timescale 1ns/1ps
module tb_top;
    reg ref_clk_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg [2:0] strap_q = 3'h4;
    reg [5:0] low_q = 6'h01;
    reg [5:0] flt_q = 6'h08;
    reg [6:0] addr_q = 7'h11;
    reg ack_q;
    reg [7:0] rd_q;
    reg [7:0] sh_rd_q;
    integer err_count = 0;
    integer compares = 0;
    wire scl, m_oe, d_oe;
    wire sda = ~(m_oe | d_oe);
    wire [5:0] drive;
    wire busy;
    initial forever #20 ref_clk_in = ~ref_clk_in;
    lfd_master u_lfd_master (.scl_out(scl), .sda_oe_out(m_oe), .sda_in(sda));
    lfd_top u_lfd_top (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .scl_in(scl),
        .serial_data_pin_in(sda), .serial_data_pin_oe_out(d_oe), .serial_data_pin_out(),
        .strap_gnd_in(strap_q[2]), .strap_scl_in(strap_q[1]), .strap_sda_in(strap_q[0]),
        .pin_low_in(low_q), .pin_fault_in(flt_q), .drive_en_out(drive), .diag_busy_out(busy));
    // ====================
    // Tasks
    task chk(input [7:0] s, input [7:0] e);
        compares = compares + 1;
        if (s !== e) begin
            err_count = err_count + 1;
            $display("wrong value t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task finish_test;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    task wait_idle;
        integer n;
        n = 0;
        while (busy !== 1'b0 && n < 1000) begin
            cyc(1);
            n = n + 1;
        end
        chk({7'h00, busy}, 8'h00);
    endtask
    task wr(input [7:0] r, input [7:0] d);
        u_lfd_master.rs;
        u_lfd_master.xb({addr_q, 1'b0}, rd_q, ack_q);
        chk({7'h00, ack_q}, 8'h01);
        u_lfd_master.xb(r, rd_q, ack_q);
        u_lfd_master.xb(d, rd_q, ack_q);
        u_lfd_master.sp;
        cyc(4);
    endtask
    task rd(input [7:0] r, input [7:0] e);
        u_lfd_master.rs;
        u_lfd_master.xb({addr_q, 1'b0}, rd_q, ack_q);
        u_lfd_master.xb(r, rd_q, ack_q);
        u_lfd_master.rs;
        u_lfd_master.xb({addr_q, 1'b1}, rd_q, ack_q);
        u_lfd_master.xb(8'hFF, rd_q, ack_q);
        u_lfd_master.sp;
        chk(rd_q, e);
    endtask
    // ====================
    // Tests
    initial begin
        for (int i = 0; i < 4; i++) begin
            cyc(1);
            rst_n_in = 1'b0;
            strap_q = 3'h4 >> i;
            addr_q = (i == 0) ? 7'h11 : (i == 1) ? 7'h15 : (i == 2) ? 7'h51 : 7'h55;
            cyc(12);
            rst_n_in = 1'b1;
            cyc(1);
            chk({7'h00, busy}, 8'h01);
            wait_idle;
            wr(8'h03, 8'h33);
            chk({2'b00, drive}, 8'h32);
        end
        wr(8'h1E, 8'h8A);
        rd(8'h1C, 8'h01);
        rd(8'h1D, 8'h09);
        // Burst read with master acknowledge, pointer auto-increments
        u_lfd_master.rs;
        u_lfd_master.xb({addr_q, 1'b0}, rd_q, ack_q);
        u_lfd_master.xb(8'h1C, rd_q, ack_q);
        u_lfd_master.rs;
        u_lfd_master.xb({addr_q, 1'b1}, rd_q, ack_q);
        u_lfd_master.xa(sh_rd_q);
        u_lfd_master.xb(8'hFF, rd_q, ack_q);
        u_lfd_master.sp;
        chk(sh_rd_q, 8'h01);
        chk(rd_q, 8'h09);
        chk(rd_q & ~sh_rd_q, 8'h08);
        wr(8'h1C, 8'hFF);
        rd(8'h1C, 8'h01);
        wr(8'h03, 8'h3F);
        chk({2'b00, drive}, 8'h3E);
        low_q = 6'h00;
        cyc(8);
        chk({2'b00, drive}, 8'h3F);
        flt_q = 6'h00;
        cyc(8);
        low_q = 6'h04;
        wr(8'h19, 8'h20);
        wait_idle;
        rd(8'h19, 8'h00);
        rd(8'h1C, 8'h04);
        rd(8'h1D, 8'h04);
        chk({2'b00, drive}, 8'h3B);
        wr(8'h1F, 8'h10);
        rd(8'h1F, 8'h00);
        addr_q = 7'h54;
        u_lfd_master.rs;
        u_lfd_master.xb({addr_q, 1'b0}, rd_q, ack_q);
        u_lfd_master.sp;
        chk({7'h00, ack_q}, 8'h00);
        finish_test;
    end
    initial begin
        #3500000;
        err_count = err_count + 1;
        finish_test;
    end
endmodule // tb_top
